// [core/clock_generator_control.sv]
// Clock generator and master clock selection, Avalon-MM register slave
// Assumes one sys_clk; all generated clocks leave as one-cycle enable ticks
//
// Overview of operation
// - Peripheral status bits 31..2 read 1 for each enabled peripheral clock.
// - Enable bit starts the oscillator; software keeps bypass at 0 meanwhile.
// - Stable flag rises only after the full start-up delay while enabled.
// - Start-up field bits 15..8 times eight gives delay in slow cycles.
// - Bypass sets stable flag at once; software keeps enable at 0.
// - Enable and bypass both 0 clear the stable flag.
// - Count field reports main clock cycles during 16 slow periods.
// - Bit 16 reads 1 only once the stable flag is set and count holds a result.
// - PLL A divider: 0 no output, 1 bypass, else divide by value.
// - Each PLL A write waits the 6-bit slow-cycle count before lock.
// - PLL A range 00 is 80-160 MHz, 10 is 150-180 MHz.
// - PLL A multiplier 0 deactivates, else output is input times value+1.
// - PLL B divider: 0 no output, 1 bypass, else divide by value.
// - Each PLL B write waits its slow-cycle count before lock.
// - PLL B range 00 is 80-160 MHz, 10 is 150-180 MHz.
// - PLL B multiplier 0 deactivates, else output is input times value+1.
// - USB bit 28 halves PLL B output for the USB clock.
// - Master source field: slow, main, PLL A, PLL B.
// - Master prescaler divides by two to the field power; 111 reserved.
// - Processor ratio bits 9..8 give processor 1 to 4 times master.
// - Four programmable clocks use the same source encoding.
// - Status bits 0..3: stable, PLL A lock, PLL B lock, master ready.
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defines.svh"
module clock_generator_control #(
  parameter int SLOW_DIV = `SYS_CLK_HZ / `SLOW_CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] periph_clock_bit,
  input wire logic osc_in_pin,
  input wire logic pll_a_tick,
  input wire logic pll_b_tick,
  output logic oscillator_enable,
  output logic oscillator_skip,
  output clock_gen_pkg::pll_cfg_t pll_a_cfg,
  output clock_gen_pkg::pll_cfg_t pll_b_cfg,
  output logic pll_a_ref_tick,
  output logic pll_b_ref_tick,
  output logic usb_clk_tick,
  output logic mck_tick,
  output logic [1:0] cpu_clock_ratio,
  output logic [3:0] programmable_clock_outputs
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return m;
  endfunction
  // Last prescaler count; reserved code held at divide by 64
  function automatic logic [6:0] clock_prescale_top(input logic [2:0] clock_prescale);
    logic [2:0] p;
    p = (clock_prescale == `CLOCK_PRESCALE_RESERVED) ? 3'h6 : clock_prescale;
    return 7'((8'h01 << p) - 8'h01);
  endfunction

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ----------------------------------------------------------------
  logic ack_r;
  logic rd_fire;
  logic wr_do;
  logic [31:0] rdata_nxt;
  logic [31:0] avs_readdata_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign rd_fire = avs_read & ~ack_r;
  assign wr_do = avs_write & ack_r;
  assign avs_readdata = avs_readdata_r;

  // Acknowledge toggles high for one cycle per request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // ----------------------------------------------------------------
  // Slow clock enable from the system clock
  // ----------------------------------------------------------------
  logic [15:0] slow_cnt_r;
  logic slow_tick_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_r <= 16'h0000;
      slow_tick_r <= 1'b0;
    end else begin
      slow_tick_r <= (slow_cnt_r == 16'(SLOW_DIV - 1));
      slow_cnt_r <= (slow_cnt_r == 16'(SLOW_DIV - 1)) ? 16'h0000 : slow_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Main oscillator control
  // ----------------------------------------------------------------
  logic osc_en_r;
  logic osc_skip_r;
  logic [7:0] osc_dly_r;
  logic [10:0] osc_cnt_r;
  logic stable_r;
  logic osc_in_d_r;
  logic main_tick;
  logic osc_drop;
  logic [31:0] mor_word;
  logic [31:0] mor_new;
  assign mor_word = {16'h0000, osc_dly_r, 6'h00, osc_skip_r, osc_en_r};
  assign mor_new = merge(mor_word, avs_writedata, avs_byteenable);
  assign main_tick = osc_in_pin & ~osc_in_d_r & stable_r;
  // Write without bypass drops the stable flag; the count result must drop with it
  assign osc_drop = wr_do && avs_address == `OFS_OSC_CTRL && !mor_new[`OSC_SKIP_BIT];
  assign oscillator_enable = osc_en_r;
  assign oscillator_skip = osc_skip_r;

  // Start-up delay and stable flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_r <= 1'b0;
      osc_skip_r <= 1'b0;
      osc_dly_r <= 8'h00;
      osc_cnt_r <= 11'h000;
      stable_r <= 1'b0;
    end else if (wr_do && avs_address == `OFS_OSC_CTRL) begin
      osc_en_r <= mor_new[`OSC_EN_BIT];
      osc_skip_r <= mor_new[`OSC_SKIP_BIT];
      osc_dly_r <= mor_new[`OSC_DLY_HI:`OSC_DLY_LO];
      osc_cnt_r <= {mor_new[`OSC_DLY_HI:`OSC_DLY_LO], 3'h0};
      if (mor_new[`OSC_SKIP_BIT]) begin
        stable_r <= 1'b1;
      end else if (!mor_new[`OSC_EN_BIT]) begin
        stable_r <= 1'b0;
      end else begin
        stable_r <= 1'b0;
      end
    end else if (osc_en_r && !stable_r) begin
      if (osc_cnt_r == 11'h000) begin
        stable_r <= 1'b1;
      end else if (slow_tick_r) begin
        osc_cnt_r <= osc_cnt_r - 11'h001;
      end
    end
  end

  // Edge detect on the oscillator pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_in_d_r <= 1'b0;
    end else begin
      osc_in_d_r <= osc_in_pin;
    end
  end

  // ----------------------------------------------------------------
  // Main clock frequency measurement
  // ----------------------------------------------------------------
  clock_gen_pkg::meas_state_t meas_r;
  logic [3:0] win_r;
  logic [15:0] acc_r;
  logic [15:0] main_clock_count_r;
  logic main_count_valid_r;
  // Counts main edges over 16 slow periods once the oscillator runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_r <= clock_gen_pkg::MEAS_IDLE;
      win_r <= 4'h0;
      acc_r <= 16'h0000;
      main_clock_count_r <= 16'h0000;
      main_count_valid_r <= 1'b0;
    end else if (!stable_r || osc_drop) begin
      meas_r <= clock_gen_pkg::MEAS_IDLE;
      main_count_valid_r <= 1'b0;
    end else begin
      case (meas_r)
        clock_gen_pkg::MEAS_IDLE: begin
          meas_r <= clock_gen_pkg::MEAS_ARM;
        end
        clock_gen_pkg::MEAS_ARM: begin
          win_r <= 4'h0;
          acc_r <= 16'h0000;
          if (slow_tick_r) begin
            meas_r <= clock_gen_pkg::MEAS_RUN;
          end
        end
        clock_gen_pkg::MEAS_RUN: begin
          if (main_tick && acc_r != 16'hFFFF) begin
            acc_r <= acc_r + 16'h0001;
          end
          if (slow_tick_r) begin
            win_r <= win_r + 4'h1;
            if (win_r == `MEAS_LAST_PERIOD) begin
              main_clock_count_r <= acc_r + {15'h0000, main_tick};
              main_count_valid_r <= 1'b1;
              meas_r <= clock_gen_pkg::MEAS_DONE;
            end
          end
        end
        default: begin
          meas_r <= clock_gen_pkg::MEAS_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // PLL A and PLL B configuration, input dividers and lock delay
  // ----------------------------------------------------------------
  clock_gen_pkg::pll_cfg_t pll_cfg_r [2];
  logic usb_halve_select_r;
  logic [5:0] lock_cnt_r [2];
  logic [7:0] div_cnt_r [2];
  logic [1:0] locked_r;
  logic [1:0] ref_tick_r;
  logic [1:0] pll_wr;
  logic [31:0] pll_word [2];
  logic [31:0] pll_new [2];
  logic [1:0] pll_out;
  assign pll_wr[0] = wr_do && avs_address == `OFS_PLL_A;
  assign pll_wr[1] = wr_do && avs_address == `OFS_PLL_B;
  assign pll_word[0] = {5'h00, pll_cfg_r[0]};
  assign pll_word[1] = {3'h0, usb_halve_select_r, 1'b0, pll_cfg_r[1]};
  assign pll_new[0] = merge(pll_word[0], avs_writedata, avs_byteenable);
  assign pll_new[1] = merge(pll_word[1], avs_writedata, avs_byteenable);
  assign pll_out = {pll_b_tick, pll_a_tick} & locked_r;
  assign pll_a_cfg = pll_cfg_r[0];
  assign pll_b_cfg = pll_cfg_r[1];
  assign pll_a_ref_tick = ref_tick_r[0];
  assign pll_b_ref_tick = ref_tick_r[1];

  // Both PLLs share one structure; a write always restarts the lock wait
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        pll_cfg_r[i] <= '0;
        lock_cnt_r[i] <= 6'h00;
        div_cnt_r[i] <= 8'h00;
      end
      locked_r <= 2'h0;
      ref_tick_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        ref_tick_r[i] <= 1'b0;
        if (pll_wr[i]) begin
          pll_cfg_r[i] <= pll_new[i][`PLL_CFG_HI:0];
          lock_cnt_r[i] <= pll_new[i][`PLL_DLY_HI:`PLL_DLY_LO];
          locked_r[i] <= 1'b0;
          div_cnt_r[i] <= 8'h00;
        end else begin
          if (!locked_r[i] && pll_cfg_r[i].mul != 11'h000) begin
            if (lock_cnt_r[i] == 6'h00) begin
              locked_r[i] <= 1'b1;
            end else if (slow_tick_r) begin
              lock_cnt_r[i] <= lock_cnt_r[i] - 6'h01;
            end
          end
          if (pll_cfg_r[i].mul == 11'h000) begin
            locked_r[i] <= 1'b0;
          end
          if (main_tick && pll_cfg_r[i].div != 8'h00) begin
            if (pll_cfg_r[i].div == 8'h01 || div_cnt_r[i] == pll_cfg_r[i].div - 8'h01) begin
              ref_tick_r[i] <= 1'b1;
              div_cnt_r[i] <= 8'h00;
            end else begin
              div_cnt_r[i] <= div_cnt_r[i] + 8'h01;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // USB clock from PLL B, optionally halved
  // ----------------------------------------------------------------
  logic usb_phase_r;
  logic usb_clk_tick_r;
  assign usb_clk_tick = usb_clk_tick_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_halve_select_r <= 1'b0;
      usb_phase_r <= 1'b0;
      usb_clk_tick_r <= 1'b0;
    end else begin
      if (pll_wr[1]) begin
        usb_halve_select_r <= pll_new[1][`PLL_USB_BIT];
      end
      if (pll_out[1]) begin
        usb_phase_r <= ~usb_phase_r;
      end
      usb_clk_tick_r <= pll_out[1] & (~usb_halve_select_r | usb_phase_r);
    end
  end

  // ----------------------------------------------------------------
  // Master clock and programmable clocks
  // ----------------------------------------------------------------
  logic [3:0] src_ticks;
  logic [1:0] mck_src_r;
  logic [2:0] mck_clock_prescale_r;
  logic [1:0] cpu_clock_ratio_r;
  logic [6:0] mck_cnt_r;
  logic mck_tick_r;
  logic mck_rdy_r;
  logic mck_wr;
  logic [31:0] mck_word;
  logic [31:0] mck_new;
  assign src_ticks = {pll_out, main_tick, slow_tick_r};
  assign mck_wr = wr_do && avs_address == `OFS_MASTER;
  assign mck_word = {22'h000000, cpu_clock_ratio_r, 3'h0, mck_clock_prescale_r, mck_src_r};
  assign mck_new = merge(mck_word, avs_writedata, avs_byteenable);
  assign mck_tick = mck_tick_r;
  assign cpu_clock_ratio = cpu_clock_ratio_r;

  // New settings restart the prescaler; only whole ticks leave
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mck_src_r <= 2'h0;
      mck_clock_prescale_r <= 3'h0;
      cpu_clock_ratio_r <= 2'h0;
      mck_cnt_r <= 7'h00;
      mck_tick_r <= 1'b0;
      mck_rdy_r <= 1'b0;
    end else begin
      mck_tick_r <= 1'b0;
      if (mck_wr) begin
        mck_src_r <= mck_new[`SRC_HI:0];
        mck_clock_prescale_r <= mck_new[`CLOCK_PRESCALE_HI:`CLOCK_PRESCALE_LO];
        cpu_clock_ratio_r <= mck_new[`RATIO_HI:`RATIO_LO];
        mck_cnt_r <= 7'h00;
        mck_rdy_r <= 1'b0;
      end else if (src_ticks[mck_src_r]) begin
        if (mck_cnt_r >= clock_prescale_top(mck_clock_prescale_r)) begin
          mck_cnt_r <= 7'h00;
          mck_tick_r <= 1'b1;
          mck_rdy_r <= 1'b1;
        end else begin
          mck_cnt_r <= mck_cnt_r + 7'h01;
        end
      end
    end
  end

  logic [1:0] pck_src_r [4];
  logic [2:0] pck_clock_prescale_r [4];
  logic [6:0] pck_cnt_r [4];
  logic [3:0] pck_rdy_r;
  logic [3:0] pck_out_r;
  logic [1:0] pck_sel;
  logic pck_wr;
  assign pck_wr = wr_do && avs_address >= `OFS_PCK_BASE && avs_address <= `OFS_PCK_LAST;
  assign pck_sel = avs_address[3:2];
  assign programmable_clock_outputs = pck_out_r;

  // Four programmable clocks with the master clock encoding
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        pck_src_r[i] <= 2'h0;
        pck_clock_prescale_r[i] <= 3'h0;
        pck_cnt_r[i] <= 7'h00;
      end
      pck_rdy_r <= 4'h0;
      pck_out_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        pck_out_r[i] <= 1'b0;
        if (pck_wr && pck_sel == 2'(i)) begin
          if (avs_byteenable[0]) begin
            pck_src_r[i] <= avs_writedata[`SRC_HI:0];
            pck_clock_prescale_r[i] <= avs_writedata[`CLOCK_PRESCALE_HI:`CLOCK_PRESCALE_LO];
          end
          pck_cnt_r[i] <= 7'h00;
          pck_rdy_r[i] <= 1'b0;
        end else if (src_ticks[pck_src_r[i]]) begin
          if (pck_cnt_r[i] >= clock_prescale_top(pck_clock_prescale_r[i])) begin
            pck_cnt_r[i] <= 7'h00;
            pck_out_r[i] <= 1'b1;
            pck_rdy_r[i] <= 1'b1;
          end else begin
            pck_cnt_r[i] <= pck_cnt_r[i] + 7'h01;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data decode, captured at the first edge of a read
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = `RESET_WORD;
    case (avs_address)
      `OFS_PERIPH_STATUS: rdata_nxt = {periph_clock_bit[31:`PERIPH_LO], 2'h0};
      `OFS_OSC_CTRL: rdata_nxt = mor_word;
      `OFS_MAIN_FREQ: rdata_nxt = {15'h0000, main_count_valid_r, main_clock_count_r};
      `OFS_PLL_A: rdata_nxt = pll_word[0];
      `OFS_PLL_B: rdata_nxt = pll_word[1];
      `OFS_MASTER: rdata_nxt = mck_word;
      `OFS_STATUS: rdata_nxt = {20'h00000, pck_rdy_r, 4'h0, mck_rdy_r, locked_r, stable_r};
      default: begin
        if (avs_address >= `OFS_PCK_BASE && avs_address <= `OFS_PCK_LAST) begin
          rdata_nxt = {27'h0000000, pck_clock_prescale_r[avs_address[3:2]], pck_src_r[avs_address[3:2]]};
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_r <= `RESET_WORD;
    end else if (rd_fire) begin
      avs_readdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and cover points
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_periph_status_read: assert property (rd_fire && avs_address == `OFS_PERIPH_STATUS
    |=> avs_readdata == {$past(periph_clock_bit[31:`PERIPH_LO]), 2'h0})
    else $error("peripheral status readback wrong");
  a_stable_after_delay: assert property ($rose(stable_r) && !osc_skip_r
    |-> $past(osc_cnt_r) == 11'h000)
    else $error("stable flag rose before delay elapsed");
  a_startup_load: assert property (wr_do && avs_address == `OFS_OSC_CTRL
    |=> osc_cnt_r == {$past(mor_new[`OSC_DLY_HI:`OSC_DLY_LO]), 3'h0})
    else $error("start-up count not loaded as field times eight");
  a_skip_sets_stable: assert property (wr_do && avs_address == `OFS_OSC_CTRL
    && mor_new[`OSC_SKIP_BIT] |=> stable_r)
    else $error("bypass did not set stable flag");
  a_off_clears_stable: assert property (wr_do && avs_address == `OFS_OSC_CTRL
    && !mor_new[`OSC_SKIP_BIT] && !mor_new[`OSC_EN_BIT] |=> !stable_r ##1 !stable_r)
    else $error("stable flag not cleared");
  a_valid_needs_osc: assert property (main_count_valid_r |-> stable_r)
    else $error("count valid without running oscillator");
  a_div_zero_silent: assert property (pll_cfg_r[0].div == 8'h00 && $stable(pll_cfg_r[0])
    |=> !ref_tick_r[0])
    else $error("divider zero produced a tick");
  a_lock_a_restart: assert property (pll_wr[0] |=> !locked_r[0])
    else $error("PLL A lock not cleared by write");
  a_lock_b_restart: assert property (pll_wr[1]
    && pll_new[1][`PLL_DLY_HI:`PLL_DLY_LO] != 6'h00
    |=> !locked_r[1] [*2])
    else $error("PLL B locked before its count");
  a_usb_direct: assert property (!usb_halve_select_r && pll_out[1] |=> usb_clk_tick_r)
    else $error("USB tick missing in direct mode");
  a_mck_ready_low: assert property (mck_wr |=> !mck_rdy_r && mck_cnt_r == 7'h00)
    else $error("master ready not dropped on change");

  c_pll_a_lock: cover property ($rose(locked_r[0]));
  c_mck_ready: cover property ($rose(mck_rdy_r));
  c_count_valid: cover property ($rose(main_count_valid_r));
  c_osc_stable: cover property ($rose(stable_r) && osc_en_r);
endmodule
`default_nettype wire

// [core/clock_gen_defines.svh]
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by bare name from the clock generator sources
`ifndef CLOCK_GEN_DEFINES_SVH
`define CLOCK_GEN_DEFINES_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_PERIPH_STATUS 8'h18
`define OFS_OSC_CTRL 8'h20
`define OFS_MAIN_FREQ 8'h24
`define OFS_PLL_A 8'h28
`define OFS_PLL_B 8'h2C
`define OFS_MASTER 8'h30
`define OFS_PCK_BASE 8'h40
`define OFS_PCK_LAST 8'h4C
`define OFS_STATUS 8'h68
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OSC_EN_BIT 0
`define OSC_SKIP_BIT 1
`define OSC_DLY_HI 15
`define OSC_DLY_LO 8
`define FREQ_VALID_BIT 16
`define PLL_CFG_HI 26
`define PLL_DLY_HI 13
`define PLL_DLY_LO 8
`define PLL_USB_BIT 28
`define SRC_HI 1
`define CLOCK_PRESCALE_HI 4
`define CLOCK_PRESCALE_LO 2
`define RATIO_HI 9
`define RATIO_LO 8
`define PERIPH_LO 2
`define ST_PCK_LO 8
// ----------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------
`define SLOW_CLK_HZ 32768
`define SYS_CLK_HZ 40000000
`define OSC_DLY_SHIFT 3
`define MEAS_LAST_PERIOD 4'hF
`define CLOCK_PRESCALE_RESERVED 3'h7
`define RESET_WORD 32'h0000_0000
`endif

// [core/clock_gen_pkg.sv]
// Types shared by the clock generator
// Assumes nothing beyond a SystemVerilog compiler
package clock_gen_pkg;
  // Configuration handed to each PLL macro
  typedef struct packed {
    logic [10:0] mul;
    logic [1:0] range;
    logic [5:0] delay;
    logic [7:0] div;
  } pll_cfg_t;
  // Clock source codes
  typedef enum logic [1:0] {
    SRC_SLOW = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_PLL_A = 2'h2,
    SRC_PLL_B = 2'h3
  } clk_src_t;
  // Main clock measurement states
  typedef enum logic [1:0] {
    MEAS_IDLE = 2'h0,
    MEAS_ARM = 2'h1,
    MEAS_RUN = 2'h2,
    MEAS_DONE = 2'h3
  } meas_state_t;
endpackage

// [verif/tb_clock_generator_control.sv]
// Self-checking bench for the clock generator control block
// Assumes the core sources and their defines header are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defines.svh"
module tb_clock_generator_control;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] periph_clock_bit = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, oscillator_enable, oscillator_skip, pll_a_ref_tick, pll_b_ref_tick;
  logic osc_in_pin = 1'b0, pll_a_tick = 1'b0, pll_b_tick = 1'b0, usb_clk_tick, mck_tick;
  clock_gen_pkg::pll_cfg_t pll_a_cfg, pll_b_cfg;
  logic [1:0] cpu_clock_ratio;
  logic [3:0] programmable_clock_outputs;
  int bad_count = 0, comparisons = 0, cycles = 0, mck_cnt = 0, usb_cnt = 0, ref_cnt = 0, c;
  int b_cnt = 0, pck_cnt = 0, c2;
  // ----------------------------------------------------------------
  // Clock, design and free-running source ticks
  // ----------------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;
  clock_generator_control #(.SLOW_DIV(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .periph_clock_bit(periph_clock_bit),
    .osc_in_pin(osc_in_pin), .pll_a_tick(pll_a_tick), .pll_b_tick(pll_b_tick),
    .oscillator_enable(oscillator_enable), .oscillator_skip(oscillator_skip),
    .pll_a_cfg(pll_a_cfg), .pll_b_cfg(pll_b_cfg), .pll_a_ref_tick(pll_a_ref_tick),
    .pll_b_ref_tick(pll_b_ref_tick), .usb_clk_tick(usb_clk_tick), .mck_tick(mck_tick),
    .cpu_clock_ratio(cpu_clock_ratio), .programmable_clock_outputs(programmable_clock_outputs));
  // Main pin and PLL ticks every second cycle, tick counters, hang guard
  always @(posedge sys_clk) begin
    osc_in_pin <= ~osc_in_pin;
    pll_a_tick <= ~pll_a_tick;
    pll_b_tick <= ~pll_b_tick;
    mck_cnt += mck_tick;
    usb_cnt += usb_clk_tick;
    ref_cnt += pll_a_ref_tick;
    b_cnt += pll_b_ref_tick;
    pck_cnt += programmable_clock_outputs[3];
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic rdbit(input logic [7:0] a, input int b, input logic exp);
    bus(1'b0, a, 32'h0000_0000);
    check({31'h0, rd[b]}, {31'h0, exp});
  endtask
  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h0000_0001);
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_map();
    rdchk(`OFS_OSC_CTRL, 32'h0000_0000);
    rdchk(`OFS_PLL_A, 32'h0000_0000);
    rdchk(`OFS_PLL_B, 32'h0000_0000);
    rdchk(`OFS_PCK_BASE, 32'h0000_0000);
    rdbit(`OFS_STATUS, 0, 1'b0);
    rdchk(`OFS_MAIN_FREQ, 32'h0000_0000);
    rdchk(8'h7C, 32'h0000_0000);
    periph_clock_bit <= 32'hA5A5_A5A7;
    rdchk(`OFS_PERIPH_STATUS, 32'hA5A5_A5A4);
  endtask
  task automatic t_oscillator();
    bus(1'b1, `OFS_OSC_CTRL, 32'h0000_0002);
    rdbit(`OFS_STATUS, 0, 1'b1);
    check({31'h0, oscillator_skip}, 32'h0000_0001);
    bus(1'b1, `OFS_OSC_CTRL, 32'h0000_0000);
    rdbit(`OFS_STATUS, 0, 1'b0);
    bus(1'b1, `OFS_OSC_CTRL, 32'h0000_0201);
    @(posedge sys_clk);
    check({31'h0, oscillator_enable}, 32'h0000_0001);
    repeat (45) @(posedge sys_clk);
    rdbit(`OFS_STATUS, 0, 1'b0);
    repeat (40) @(posedge sys_clk);
    rdbit(`OFS_STATUS, 0, 1'b1);
    rdbit(`OFS_MAIN_FREQ, 16, 1'b0);
    repeat (120) @(posedge sys_clk);
    rdbit(`OFS_MAIN_FREQ, 16, 1'b1);
    in_range(rd[15:0], 31, 33);
  endtask
  task automatic t_plls();
    bus(1'b1, `OFS_PLL_A, 32'h0005_8203);
    @(posedge sys_clk);
    check(pll_a_cfg, {5'h0, 11'h005, 2'h2, 6'h02, 8'h03});
    rdbit(`OFS_STATUS, 1, 1'b0);
    repeat (30) @(posedge sys_clk);
    rdbit(`OFS_STATUS, 1, 1'b1);
    c = ref_cnt;
    repeat (300) @(posedge sys_clk);
    in_range(ref_cnt - c, 49, 51);
    bus(1'b1, `OFS_PLL_B, 32'h1001_0101);
    @(posedge sys_clk);
    check(pll_b_cfg, {5'h0, 11'h001, 2'h0, 6'h01, 8'h01});
    repeat (20) @(posedge sys_clk);
    rdbit(`OFS_STATUS, 2, 1'b1);
    rdchk(`OFS_PLL_B, 32'h1001_0101);
    c = usb_cnt;
    c2 = b_cnt;
    repeat (200) @(posedge sys_clk);
    in_range(usb_cnt - c, 49, 51);
    in_range(b_cnt - c2, 99, 101);
    // Direct USB feed; each write differs from the value held
    bus(1'b1, `OFS_PLL_B, 32'h0001_0101);
    repeat (20) @(posedge sys_clk);
    c = usb_cnt;
    repeat (200) @(posedge sys_clk);
    in_range(usb_cnt - c, 99, 101);
  endtask
  task automatic t_master();
    bus(1'b1, `OFS_MASTER, 32'h0000_031A);
    rdbit(`OFS_STATUS, 3, 1'b0);
    check({30'h0, cpu_clock_ratio}, 32'h0000_0003);
    repeat (200) @(posedge sys_clk);
    rdbit(`OFS_STATUS, 3, 1'b1);
    c = mck_cnt;
    repeat (512) @(posedge sys_clk);
    in_range(mck_cnt - c, 3, 5);
    bus(1'b1, `OFS_PCK_LAST, 32'h0000_0003);
    rdchk(`OFS_PCK_LAST, 32'h0000_0003);
    c = pck_cnt;
    repeat (100) @(posedge sys_clk);
    in_range(pck_cnt - c, 49, 51);
    // Main clock, then slow clock, both undivided
    bus(1'b1, `OFS_MASTER, 32'h0000_0001);
    repeat (4) @(posedge sys_clk);
    c = mck_cnt;
    repeat (100) @(posedge sys_clk);
    in_range(mck_cnt - c, 49, 51);
    bus(1'b1, `OFS_MASTER, 32'h0000_0000);
    repeat (8) @(posedge sys_clk);
    c = mck_cnt;
    repeat (100) @(posedge sys_clk);
    in_range(mck_cnt - c, 24, 26);
    bus(1'b1, `OFS_PLL_A, 32'h0000_0003);
    repeat (30) @(posedge sys_clk);
    rdbit(`OFS_STATUS, 1, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset_map();
    t_oscillator();
    t_plls();
    t_master();
    complete_run();
  end
endmodule
`default_nettype wire
